// ==== rtl/tpa_pkg.sv ====
// shared constants and types of the timer pulse accumulator block
package tpa_pkg;
	// -----------------------------------------------------------------
	// register offsets (byte addresses on the plain register port)
	// -----------------------------------------------------------------
	localparam logic [7:0] OFS_CH7 = 8'h9e;
	localparam logic [7:0] OFS_SYSCTL = 8'h86;
	localparam logic [7:0] OFS_SELECT = 8'h80;
	localparam logic [7:0] OFS_OCEN = 8'h8a;
	localparam logic [7:0] OFS_ACTL = 8'ha0;
	localparam logic [7:0] OFS_AFLG = 8'ha1;
	localparam logic [7:0] OFS_ACNT = 8'ha2;
	localparam logic [7:0] OFS_TEST = 8'had;
	localparam logic [7:0] OFS_PORT = 8'hae;
	localparam logic [7:0] OFS_DDR = 8'haf;
	localparam logic [7:0] OFS_CNT = 8'h84;
	// -----------------------------------------------------------------
	// field positions
	// -----------------------------------------------------------------
	localparam int ACTL_EN = 6;
	localparam int ACTL_MOD = 5;
	localparam int ACTL_EDGE = 4;
	localparam int ACTL_COUNTER_CLOCK_SELECT_HI = 3;
	localparam int ACTL_COUNTER_CLOCK_SELECT_LO = 2;
	localparam int ACTL_OVIE = 1;
	localparam int ACTL_INIE = 0;
	localparam int AFLG_OVF = 1;
	localparam int AFLG_INF = 0;
	localparam int SYS_TEN = 7;
	localparam int SYS_WAI = 6;
	localparam int SYS_BCK = 5;
	localparam int SYS_FFCA = 4;
	localparam int TST_TIMER_CHAIN_BYPASS = 1;
	localparam int TST_ACCUMULATOR_CHAIN_BYPASS = 0;
	localparam int CH7 = 7;
	// -----------------------------------------------------------------
	// reset values and timing
	// -----------------------------------------------------------------
	localparam logic [15:0] RST_CH7 = 16'h0000;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [7:0] RST_PINS = 8'hff; // pins idle high on their pull-ups
	localparam int GATE_DIV = 64;
	localparam logic [5:0] GATE_LAST = 6'(GATE_DIV - 1);
	localparam logic [2:0] PRESCALE_LAST = 3'h3;
	// counter clock source choice
	typedef enum logic [1:0] {
		TPA_SRC_PRESCALER,
		TPA_SRC_ACLK,
		TPA_SRC_ACLK_256,
		TPA_SRC_ACLK_64K
	} tpa_src_t;
	// register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} tpa_req_t;
endpackage

// ==== rtl/tpa_half_counter.sv ====
// one 8-bit counter half with carry out, used for split test chains
`timescale 1ns/1ps
`default_nettype none
module tpa_half_counter (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic load,
	input wire logic [7:0] load_val,
	input wire logic inc,
	output logic [7:0] value,
	output logic wrap
);
	// wrap flags all-ones reached while counting
	assign wrap = inc && (value == 8'hff);
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			value <= tpa_pkg::RST_BYTE;
		end else if (load) begin
			value <= load_val;
		end else if (inc) begin
			value <= value + 8'h01;
		end
	end
endmodule
`default_nettype wire

// ==== rtl/tpa_timer_accum.sv ====
// timer channel 7, pulse accumulator, clock select, test and port registers
`timescale 1ns/1ps
`default_nettype none
module tpa_timer_accum (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire tpa_pkg::tpa_req_t req,
	output logic [15:0] rdata,
	input wire logic [7:0] port_in,
	output logic [7:0] port_out,
	output logic [7:0] port_oe,
	input wire logic special_mode_low,
	input wire logic background_mode,
	input wire logic wait_mode,
	output logic accumulator_overflow_irq,
	output logic accumulator_input_irq,
	output logic [15:0] counter_value
);
	// -----------------------------------------------------------------
	// pin synchroniser
	// -----------------------------------------------------------------
	logic [7:0] pin_s1_r;
	logic [7:0] pin_s2_r;
	logic pin7_d_r;
	// two stages before any logic sees a pin
	// reset to the idle pin level so no false edge follows reset
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pin_s1_r <= tpa_pkg::RST_PINS;
			pin_s2_r <= tpa_pkg::RST_PINS;
			pin7_d_r <= tpa_pkg::RST_PINS[tpa_pkg::CH7];
		end else begin
			pin_s1_r <= port_in;
			pin_s2_r <= pin_s1_r;
			pin7_d_r <= pin_s2_r[tpa_pkg::CH7];
		end
	end
	// -----------------------------------------------------------------
	// registers
	// -----------------------------------------------------------------
	logic [15:0] ch7_r;
	logic [7:0] sysctl_r;
	logic [7:0] select_r;
	logic [7:0] ocen_r;
	logic [7:0] actl_r;
	logic [1:0] aflg_r;
	logic [1:0] aflg_nxt;
	logic [1:0] test_r;
	logic [7:0] port_latch_r;
	logic [7:0] ddr_r;
	logic [2:0] pre_r;
	logic [5:0] gdiv_r;
	logic [15:0] rdata_nxt;
	// address decode
	wire hit_ch7 = req.addr == tpa_pkg::OFS_CH7;
	wire hit_sys = req.addr == tpa_pkg::OFS_SYSCTL;
	wire hit_sel = req.addr == tpa_pkg::OFS_SELECT;
	wire hit_ocen = req.addr == tpa_pkg::OFS_OCEN;
	wire hit_actl = req.addr == tpa_pkg::OFS_ACTL;
	wire hit_aflg = req.addr == tpa_pkg::OFS_AFLG;
	wire hit_acnt = req.addr == tpa_pkg::OFS_ACNT;
	wire hit_test = req.addr == tpa_pkg::OFS_TEST;
	wire hit_port = req.addr == tpa_pkg::OFS_PORT;
	wire hit_ddr = req.addr == tpa_pkg::OFS_DDR;
	// control fields
	wire ch7_compare = select_r[tpa_pkg::CH7];
	wire acc_en = actl_r[tpa_pkg::ACTL_EN];
	wire acc_gated = actl_r[tpa_pkg::ACTL_MOD];
	wire acc_edge = actl_r[tpa_pkg::ACTL_EDGE];
	wire [1:0] clk_sel = {actl_r[tpa_pkg::ACTL_COUNTER_CLOCK_SELECT_HI], actl_r[tpa_pkg::ACTL_COUNTER_CLOCK_SELECT_LO]};
	wire fast_clear = sysctl_r[tpa_pkg::SYS_FFCA];
	wire timer_bypass = test_r[tpa_pkg::TST_TIMER_CHAIN_BYPASS];
	wire acc_bypass = test_r[tpa_pkg::TST_ACCUMULATOR_CHAIN_BYPASS];
	// timer runs unless disabled or stopped by mode
	wire timer_run = sysctl_r[tpa_pkg::SYS_TEN]
		&& !(background_mode && sysctl_r[tpa_pkg::SYS_BCK])
		&& !(wait_mode && sysctl_r[tpa_pkg::SYS_WAI]);
	// -----------------------------------------------------------------
	// prescaler and divide-by-64 gate clock
	// -----------------------------------------------------------------
	wire pre_tick = timer_run && (pre_r == tpa_pkg::PRESCALE_LAST);
	// gate tick only exists while the timer runs
	wire gate_tick = timer_run && (gdiv_r == tpa_pkg::GATE_LAST);
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pre_r <= 3'h0;
			gdiv_r <= 6'h00;
		end else if (timer_run) begin
			pre_r <= pre_tick ? 3'h0 : pre_r + 3'h1;
			gdiv_r <= gdiv_r + 6'h01;
		end
	end
	// -----------------------------------------------------------------
	// accumulator event detection
	// -----------------------------------------------------------------
	wire pin7 = pin_s2_r[tpa_pkg::CH7];
	wire rise7 = pin7 && !pin7_d_r;
	wire fall7 = !pin7 && pin7_d_r;
	// edge bit picks rising or falling
	wire sel_edge = acc_edge ? rise7 : fall7;
	// gate open on high at edge 0, low at edge 1
	wire gate_open = acc_edge ? !pin7 : pin7;
	// trailing edge of gate: falling at edge 0, rising at edge 1
	wire trail_edge = acc_edge ? rise7 : fall7;
	// mode bit selects counting source
	wire acc_event = acc_gated ? (gate_open && gate_tick) : sel_edge;
	// accumulator halts when disabled
	wire acc_inc = acc_en && (acc_bypass ? 1'b1 : acc_event);
	wire flag_edge = acc_en && (acc_gated ? trail_edge : sel_edge);
	// -----------------------------------------------------------------
	// accumulator count, two halves
	// -----------------------------------------------------------------
	logic [7:0] acc_lo;
	logic [7:0] acc_hi;
	logic acc_lo_wrap;
	logic acc_hi_wrap;
	wire acc_wr = req.wr && hit_acnt;
	// split halves both count directly in bypass
	wire acc_hi_inc = acc_bypass ? acc_inc : acc_lo_wrap;
	// count by one per event, wrapping
	tpa_half_counter u_acc_lo (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.load(acc_wr),
		.load_val(req.wdata[7:0]),
		.inc(acc_inc),
		.value(acc_lo),
		.wrap(acc_lo_wrap)
	);
	tpa_half_counter u_acc_hi (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.load(acc_wr),
		.load_val(req.wdata[15:8]),
		.inc(acc_hi_inc),
		.value(acc_hi),
		.wrap(acc_hi_wrap)
	);
	// full 16-bit wrap from all ones to zero
	wire acc_ovf = !acc_bypass && acc_hi_wrap;
	// -----------------------------------------------------------------
	// main counter clock select and counter halves
	// -----------------------------------------------------------------
	// the accumulator doubles as the divider chain for the counter clock
	wire aclk_pulse = acc_inc;
	// low half carry is one per 256 pulses, full wrap one per 65536
	wire aclk_256 = !acc_bypass && acc_lo_wrap;
	wire aclk_64k = acc_ovf;
	// disabled accumulator forces prescaler; decoded live so a write applies at once
	wire [1:0] eff_sel = acc_en ? clk_sel : 2'b00;
	logic cnt_src;
	// source table
	always_comb begin
		case (tpa_pkg::tpa_src_t'(eff_sel))
			tpa_pkg::TPA_SRC_PRESCALER: cnt_src = pre_tick;
			tpa_pkg::TPA_SRC_ACLK: cnt_src = aclk_pulse;
			tpa_pkg::TPA_SRC_ACLK_256: cnt_src = aclk_256;
			default: cnt_src = aclk_64k;
		endcase
	end
	logic [7:0] cnt_lo;
	logic [7:0] cnt_hi;
	logic cnt_lo_wrap;
	// bypass clocks both halves straight from module clock
	wire cnt_lo_inc = timer_run && (timer_bypass ? 1'b1 : cnt_src);
	wire cnt_hi_inc = timer_bypass ? timer_run : cnt_lo_wrap;
	tpa_half_counter u_cnt_lo (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.load(1'b0),
		.load_val(8'h00),
		.inc(cnt_lo_inc),
		.value(cnt_lo),
		.wrap(cnt_lo_wrap)
	);
	tpa_half_counter u_cnt_hi (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.load(1'b0),
		.load_val(8'h00),
		.inc(cnt_hi_inc),
		.value(cnt_hi),
		.wrap()
	);
	wire [15:0] cnt_now = {cnt_hi, cnt_lo};
	// -----------------------------------------------------------------
	// channel 7 capture or compare
	// -----------------------------------------------------------------
	// capture on either synchronised edge of the channel pin
	wire ch7_capture = !ch7_compare && timer_run && (rise7 || fall7);
	wire ch7_match = ch7_compare && (cnt_now == ch7_r);
	logic oc7_level_r;
	logic ch7_match_d_r;
	// act once as the counter reaches the value, not on every held cycle
	wire ch7_hit = ch7_match && !ch7_match_d_r;
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ch7_r <= tpa_pkg::RST_CH7;
			oc7_level_r <= 1'b0;
			ch7_match_d_r <= 1'b0;
		end else begin
			ch7_match_d_r <= ch7_match;
			if (ch7_capture) begin
				ch7_r <= cnt_now;
			end else if (req.wr && hit_ch7 && ch7_compare) begin
				ch7_r <= req.wdata;
			end
			if (ch7_hit && timer_run) begin
				oc7_level_r <= !oc7_level_r; // compare action toggles line
			end
		end
	end
	// -----------------------------------------------------------------
	// flags
	// -----------------------------------------------------------------
	// access side effect only with fast clear set
	wire fast_hit = fast_clear && hit_acnt && (req.wr || req.rd);
	wire [1:0] w1c = (req.wr && hit_aflg) ? req.wdata[1:0] : 2'b00;
	// set wins over clear in the same cycle
	always_comb begin
		aflg_nxt = fast_hit ? 2'b00 : (aflg_r & ~w1c);
		if (acc_ovf) begin
			aflg_nxt[tpa_pkg::AFLG_OVF] = 1'b1;
		end
		if (flag_edge) begin
			aflg_nxt[tpa_pkg::AFLG_INF] = 1'b1;
		end
	end
	// -----------------------------------------------------------------
	// control register writes
	// -----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			sysctl_r <= tpa_pkg::RST_BYTE;
			select_r <= tpa_pkg::RST_BYTE;
			ocen_r <= tpa_pkg::RST_BYTE;
			actl_r <= tpa_pkg::RST_BYTE;
			aflg_r <= 2'b00;
			test_r <= 2'b00;
			port_latch_r <= tpa_pkg::RST_BYTE;
			ddr_r <= tpa_pkg::RST_BYTE;
		end else begin
			aflg_r <= aflg_nxt;
			if (req.wr && hit_sys) sysctl_r <= req.wdata[7:0];
			if (req.wr && hit_sel) select_r <= req.wdata[7:0];
			if (req.wr && hit_ocen) ocen_r <= req.wdata[7:0];
			if (req.wr && hit_actl) actl_r <= req.wdata[7:0];
			if (req.wr && hit_test && !special_mode_low) test_r <= req.wdata[1:0];
			if (req.wr && hit_port) port_latch_r <= req.wdata[7:0];
			if (req.wr && hit_ddr) ddr_r <= req.wdata[7:0];
		end
	end
	// -----------------------------------------------------------------
	// port pins
	// -----------------------------------------------------------------
	// enabled compare forces output, latch kept; capture does not
	wire [7:0] oc_force = ocen_r & select_r;
	wire [7:0] drv_level = {oc_force[tpa_pkg::CH7] ? oc7_level_r : port_latch_r[7],
		port_latch_r[6:0]};
	wire [7:0] pin_oe = ddr_r | oc_force;
	// inputs read pin, outputs read driver input
	wire [7:0] port_read = (pin_oe & drv_level) | (~pin_oe & pin_s2_r);
	// -----------------------------------------------------------------
	// read mux
	// -----------------------------------------------------------------
	// unmapped addresses read zero
	always_comb begin
		rdata_nxt = 16'h0000;
		if (hit_ch7) begin
			rdata_nxt = ch7_r;
		end else if (hit_sys) begin
			rdata_nxt = {8'h00, sysctl_r};
		end else if (hit_sel) begin
			rdata_nxt = {8'h00, select_r};
		end else if (hit_ocen) begin
			rdata_nxt = {8'h00, ocen_r};
		end else if (hit_actl) begin
			rdata_nxt = {8'h00, actl_r};
		end else if (hit_aflg) begin
			rdata_nxt = {14'h0000, aflg_r};
		end else if (hit_acnt) begin
			rdata_nxt = {acc_hi, acc_lo}; // whole word in one cycle
		end else if (hit_test) begin
			rdata_nxt = {14'h0000, test_r};
		end else if (hit_port) begin
			rdata_nxt = {8'h00, port_read};
		end else if (hit_ddr) begin
			rdata_nxt = {8'h00, ddr_r};
		end else if (req.addr == tpa_pkg::OFS_CNT) begin
			rdata_nxt = cnt_now;
		end
	end
	// -----------------------------------------------------------------
	// registered outputs
	// -----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rdata <= tpa_pkg::RST_WORD;
			port_out <= tpa_pkg::RST_BYTE;
			port_oe <= tpa_pkg::RST_BYTE;
			accumulator_overflow_irq <= 1'b0;
			accumulator_input_irq <= 1'b0;
			counter_value <= tpa_pkg::RST_WORD;
		end else begin
			rdata <= req.rd ? rdata_nxt : 16'h0000;
			port_out <= drv_level;
			port_oe <= pin_oe;
			accumulator_overflow_irq <= aflg_nxt[tpa_pkg::AFLG_OVF]
				&& actl_r[tpa_pkg::ACTL_OVIE];
			accumulator_input_irq <= aflg_nxt[tpa_pkg::AFLG_INF]
				&& actl_r[tpa_pkg::ACTL_INIE];
			counter_value <= cnt_now;
		end
	end
endmodule
`default_nettype wire

// ==== bench/tpa_pin_model.sv ====
// pin-side model: timer port pins and the accumulator input pin
`timescale 1ns/1ps
`default_nettype none
module tpa_pin_model (
	input wire logic mclk,
	input wire logic [7:0] port_out,
	input wire logic [7:0] port_oe,
	output logic [7:0] port_in
);
	logic acc_lvl = 1'b1;
	// driven pins read back their driver, undriven pins 0 to 6 sit on the pull-up, undriven pin 7 on the accumulator level
	always_comb begin
		port_in = (port_oe & port_out) | (~port_oe & {acc_lvl, 7'h7f});
	end
	// each level is held four clocks, longer than the input synchroniser
	task automatic pulse(input int n);
		repeat (2 * n) begin
			@(posedge mclk);
			acc_lvl <= ~acc_lvl;
			repeat (3) @(posedge mclk);
		end
	endtask
	// set a steady level, then give the synchroniser time to settle
	task automatic hold(input logic lvl);
		@(posedge mclk);
		acc_lvl <= lvl;
		repeat (4) @(posedge mclk);
	endtask
endmodule
`default_nettype wire

// ==== bench/tpa_timer_accum_asserts.sv ====
// checker with port-level relations of the timer pulse accumulator
`timescale 1ns/1ps
`default_nettype none
module tpa_timer_accum_asserts (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire tpa_pkg::tpa_req_t req,
	input wire logic [15:0] rdata,
	input wire logic [7:0] port_in,
	input wire logic [7:0] port_out,
	input wire logic [7:0] port_oe,
	input wire logic special_mode_low,
	input wire logic background_mode,
	input wire logic wait_mode,
	input wire logic accumulator_overflow_irq,
	input wire logic accumulator_input_irq,
	input wire logic [15:0] counter_value
);
	// ------------------------------------------
	// register shadows and settle counters
	// ------------------------------------------
	logic [7:0] sel_r, oc_r, sys_r, actl_r, tst_r, port_r, ddr_r;
	logic [1:0] quiet_r, stop_r;
	// decoded helpers
	wire logic [7:0] wd = req.wdata[7:0];
	wire logic [1:0] tst_lo = tst_r[1:0];
	wire logic cnt_acc = (req.wr | req.rd) & (req.addr == tpa_pkg::OFS_ACNT);
	wire logic [7:0] forced = sel_r & oc_r;
	wire logic stop = ~sys_r[7] | (sys_r[6] & wait_mode) | (sys_r[5] & background_mode);
	wire logic settled = (quiet_r == 2'h3) & ~tst_r[1];
	// shadows follow writes; quiet and stop count calm cycles
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			{sel_r, oc_r, sys_r, actl_r, tst_r, port_r, ddr_r} <= '0;
			quiet_r <= 2'h0;
			stop_r <= 2'h0;
		end else begin
			if (req.wr) begin
				case (req.addr)
					tpa_pkg::OFS_SELECT: sel_r <= wd;
					tpa_pkg::OFS_OCEN: oc_r <= wd;
					tpa_pkg::OFS_SYSCTL: sys_r <= wd;
					tpa_pkg::OFS_ACTL: actl_r <= wd;
					tpa_pkg::OFS_TEST: if (!special_mode_low) tst_r <= wd;
					tpa_pkg::OFS_PORT: port_r <= wd;
					tpa_pkg::OFS_DDR: ddr_r <= wd;
					default: ;
				endcase
			end
			quiet_r <= req.wr ? 2'h0 : quiet_r + 2'(quiet_r != 2'h3);
			stop_r <= (req.wr | ~stop) ? 2'h0 : stop_r + 2'(stop_r != 2'h3);
		end
	end
	// ------------------------------------------
	// assertions
	// ------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	sequence s_running;
		(settled && !stop && !actl_r[6])[*4];
	endsequence
	AST_PRESCALER_RUNS: assert property (s_running |-> ##[0:4] $changed(counter_value))
		else $error("counter idle on prescaler clock");
	AST_STOP_HOLDS: assert property (stop_r == 2'h3 && settled |=> $stable(counter_value))
		else $error("counter moved while stopped");
	AST_TEST_READ: assert property ($past(req.rd && req.addr == tpa_pkg::OFS_TEST) |-> rdata[1:0] == $past(tst_lo))
		else $error("test register readback wrong");
	AST_DDR_READ: assert property ($past(req.rd && req.addr == tpa_pkg::OFS_DDR) |-> rdata[7:0] == $past(ddr_r))
		else $error("direction readback wrong");
	AST_DIR_OE: assert property (quiet_r == 2'h3 |-> port_oe == (ddr_r | forced))
		else $error("output enables wrong");
	AST_PORT_DRIVE: assert property (quiet_r == 2'h3 |-> (port_out & ddr_r & ~forced) == (port_r & ddr_r & ~forced))
		else $error("port driver level wrong");
	AST_OVF_MASK: assert property (!actl_r[1] [*2] |-> !accumulator_overflow_irq)
		else $error("overflow request while masked");
	AST_IN_MASK: assert property (!actl_r[0] [*2] |-> !accumulator_input_irq)
		else $error("input request while masked");
	AST_OVF_CLR: assert property (req.wr && req.addr == tpa_pkg::OFS_AFLG && req.wdata[1] |=> !accumulator_overflow_irq)
		else $error("overflow flag not cleared");
	AST_IN_CLR: assert property (req.wr && req.addr == tpa_pkg::OFS_AFLG && req.wdata[0] |=> !accumulator_input_irq)
		else $error("input flag not cleared");
	AST_FAST_CLR: assert property (cnt_acc && sys_r[4] |=> !accumulator_overflow_irq && !accumulator_input_irq)
		else $error("fast clear missed");
	AST_NO_SIDE_CLR: assert property (accumulator_overflow_irq && req.rd && cnt_acc && !sys_r[4] |=> accumulator_overflow_irq)
		else $error("flag cleared by a count read");
endmodule
bind tpa_timer_accum tpa_timer_accum_asserts chk (.mclk(mclk), .sys_rst(sys_rst), .req(req),
	.rdata(rdata), .port_in(port_in), .port_out(port_out), .port_oe(port_oe),
	.special_mode_low(special_mode_low), .background_mode(background_mode), .wait_mode(wait_mode),
	.accumulator_overflow_irq(accumulator_overflow_irq),
	.accumulator_input_irq(accumulator_input_irq), .counter_value(counter_value));
`default_nettype wire

// ==== bench/tb.sv ====
// self-checking bench for the timer pulse accumulator
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
	$display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	tpa_pkg::tpa_req_t req = '0;
	logic special_mode_low = 1'b1;
	logic background_mode = 1'b0;
	logic wait_mode = 1'b0;
	logic [15:0] rdata, counter_value, v, w, u;
	logic [7:0] port_in, port_out, port_oe;
	logic ovf_irq, in_irq, p7;
	logic [15:0] st [1:3] = '{16'h0000, 16'h00fe, 16'hfffe};
	int err_count = 0;
	int n_compared = 0;
	// clock
	always #12.5 mclk = ~mclk;
	tpa_timer_accum uut (.mclk(mclk), .sys_rst(sys_rst), .req(req), .rdata(rdata),
		.port_in(port_in), .port_out(port_out), .port_oe(port_oe),
		.special_mode_low(special_mode_low), .background_mode(background_mode),
		.wait_mode(wait_mode), .accumulator_overflow_irq(ovf_irq),
		.accumulator_input_irq(in_irq), .counter_value(counter_value));
	tpa_pin_model pins (.mclk(mclk), .port_out(port_out), .port_oe(port_oe), .port_in(port_in));
	// ------------------------------------------
	// bus tasks
	// ------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		req.wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge mclk);
		req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		req.rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic rc(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] d;
		rd(a, d);
		`CHK(d, e)
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic conclude();
		$display("compared %0d, mismatched %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// watchdog, nearly thirty times the expected run
	initial begin
		cyc(40000);
		err_count++;
		conclude();
	end
	// ------------------------------------------
	// tests
	// ------------------------------------------
	initial begin
		cyc(20);
		sys_rst <= 1'b0;
		rc(tpa_pkg::OFS_CH7, tpa_pkg::RST_CH7);
		rc(8'h90, 16'h0000);
		wr(tpa_pkg::OFS_CH7, 16'h1234);
		rc(tpa_pkg::OFS_CH7, 16'h0000);
		wr(tpa_pkg::OFS_SELECT, 16'h0080);
		wr(tpa_pkg::OFS_CH7, 16'h1234);
		rc(tpa_pkg::OFS_CH7, 16'h1234);
		$display("done: channel register");
		for (int e = 0; e < 2; e++) begin
			wr(tpa_pkg::OFS_ACTL, 16'h0041 | 16'(e << 4));
			wr(tpa_pkg::OFS_ACNT, 16'h0000);
			pins.pulse(3);
			cyc(6);
			rc(tpa_pkg::OFS_ACNT, 16'h0003);
			`CHK(in_irq, 1'b1)
			wr(tpa_pkg::OFS_AFLG, 16'h0001);
			`CHK(in_irq, 1'b0)
		end
		wr(tpa_pkg::OFS_ACTL, 16'h0001);
		pins.pulse(2);
		rc(tpa_pkg::OFS_ACNT, 16'h0003);
		for (int f = 0; f < 2; f++) begin
			wr(tpa_pkg::OFS_SYSCTL, 16'(f << 4));
			wr(tpa_pkg::OFS_ACTL, 16'h0042);
			wr(tpa_pkg::OFS_ACNT, 16'hffff);
			pins.pulse(1);
			cyc(6);
			`CHK(ovf_irq, 1'b1)
			rc(tpa_pkg::OFS_ACNT, 16'h0000);
			`CHK(ovf_irq, f == 0)
			wr(tpa_pkg::OFS_AFLG, 16'h0002);
			`CHK(ovf_irq, 1'b0)
		end
		$display("done: event counting and flags");
		wr(tpa_pkg::OFS_SYSCTL, 16'h0080);
		for (int k = 1; k < 4; k++) begin
			wr(tpa_pkg::OFS_ACTL, 16'h0040 | 16'(k << 2));
			wr(tpa_pkg::OFS_ACNT, st[k]);
			v = counter_value;
			pins.pulse(3);
			cyc(6);
			`CHK(counter_value - v, 16'(k == 1 ? 3 : 1))
		end
		wr(tpa_pkg::OFS_ACTL, 16'h0004);
		v = counter_value;
		cyc(40);
		v = counter_value - v;
		`CHK(v >= 16'h0009 && v <= 16'h000b, 1'b1)
		for (int m = 0; m < 3; m++) begin
			wr(tpa_pkg::OFS_SYSCTL, 16'h0080 | (m == 1 ? 16'h0040 : 16'h0000) | (m == 2 ? 16'h0020 : 16'h0000));
			wait_mode <= (m != 2);
			background_mode <= (m != 1);
			cyc(4);
			v = counter_value;
			cyc(20);
			`CHK(counter_value === v, m != 0)
		end
		wait_mode <= 1'b0;
		background_mode <= 1'b0;
		$display("done: clock select and modes");
		for (int g = 0; g < 3; g++) begin
			wr(tpa_pkg::OFS_SYSCTL, g == 2 ? 16'h0000 : 16'h0080);
			wr(tpa_pkg::OFS_ACTL, (g == 1) ? 16'h0071 : 16'h0061);
			pins.hold(g == 1);
			wr(tpa_pkg::OFS_ACNT, 16'h0000);
			wr(tpa_pkg::OFS_AFLG, 16'h0003);
			pins.hold(g != 1);
			cyc(252);
			pins.hold(g == 1);
			cyc(4);
			rd(tpa_pkg::OFS_ACNT, v);
			`CHK(v >= 16'h0003 && v <= 16'h0005, g != 2)
			`CHK(in_irq, 1'b1)
		end
		$display("done: gated accumulation");
		wr(tpa_pkg::OFS_TEST, 16'h0003);
		rc(tpa_pkg::OFS_TEST, 16'h0000);
		special_mode_low <= 1'b0;
		wr(tpa_pkg::OFS_TEST, 16'h0003);
		rc(tpa_pkg::OFS_TEST, 16'h0003);
		wr(tpa_pkg::OFS_SYSCTL, 16'h0080);
		wr(tpa_pkg::OFS_ACTL, 16'h0040);
		wr(tpa_pkg::OFS_ACNT, 16'h0000);
		cyc(10);
		rd(tpa_pkg::OFS_ACNT, v);
		`CHK({v[15:8] == v[7:0], v[7:0] > 8'h05}, 2'h3)
		v = counter_value;
		@(posedge mclk);
		#1 `CHK({counter_value[15:8] - v[15:8], counter_value[7:0] - v[7:0]}, 16'h0101)
		wr(tpa_pkg::OFS_TEST, 16'h0000);
		$display("done: test register");
		pins.hold(1'b1);
		wr(tpa_pkg::OFS_DDR, 16'h000f);
		wr(tpa_pkg::OFS_PORT, 16'h00a5);
		cyc(2);
		`CHK({port_oe, port_out[3:0]}, 12'h0f5)
		rc(tpa_pkg::OFS_PORT, 16'h00f5);
		wr(tpa_pkg::OFS_OCEN, 16'h0080);
		cyc(2);
		`CHK(port_oe, 8'h8f)
		rc(tpa_pkg::OFS_DDR, 16'h000f);
		rd(tpa_pkg::OFS_CNT, v);
		wr(tpa_pkg::OFS_CH7, v + 16'h0010);
		p7 = port_out[7];
		cyc(80);
		`CHK(port_out[7], ~p7)
		wr(tpa_pkg::OFS_SELECT, 16'h0000);
		cyc(2);
		`CHK(port_oe, 8'h0f)
		rd(tpa_pkg::OFS_CNT, v);
		pins.pulse(1);
		rd(tpa_pkg::OFS_CH7, w);
		rd(tpa_pkg::OFS_CNT, u);
		`CHK(w >= v && w <= u, 1'b1)
		$display("done: port pins");
		conclude();
	end
endmodule
`default_nettype wire
